//--- hdl/hbs_sequencer.sv
// Purpose: runs multiplexed host bus write and read cycles as bus master
// Assumes: commands come from logic on i_clk; pins are asynchronous
// Notes: phases advance on bus clock rising ticks, releases on falling
// How it works
// (RL1) extended write: high byte first, then low
// (RL2) low address stable one clock before latch
// (RL3) write latch strobe two clocks when waiting
// (RL4) write latch strobe falls as select asserts
// (RL5) write data driven one clock before strobe
// (RL6) write strobe low six clocks when waiting
// (RL7) write select released half clock after strobe
// (RL8) write data held until select released
// (RL9) plain read skips the high address byte
// (RL10) read latch strobe two clocks when waiting
// (RL11) read select phase three clocks when waiting
// (RL12) read select falls one clock after latch
// (RL13) read: bus released as read strobe falls
// (RL14) read strobe low one clock, five waiting
// (RL15) read select and bus back half clock later
// (RL16) bus clock driven out on its pin
// (RL17) peripheral pulls wait low for more time
// (RL18) high address byte on extended address lines
// (RL19) commands stall until aux pin high/low
// (RL20) plain write skips the high address byte
`timescale 1ns/1ps
module hbs_sequencer import hbs_pkg::*; #(
	parameter int HALF = BCLK_HALF_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// command port
	input wire logic i_cmd_valid,
	input wire hbs_op_t i_cmd_op,
	input wire logic [15:0] i_cmd_addr,
	input wire logic [7:0] i_cmd_wdata,
	output logic o_cmd_ready,
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	// peripheral pins
	input wire logic i_wait_ready_in,
	input wire logic i_aux_wait_pin,
	input wire logic [7:0] i_ad_in,
	output logic [7:0] o_ad_out,
	output logic o_ad_oe,
	output logic [7:0] o_ext_addr,
	output logic o_ale,
	output logic o_cs_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_bus_clock_out
);
	hbs_link_if lk ();
	hbs_seq_t st;
	hbs_seq_t next_st;
	logic take;
	logic is_rd;
	logic [2:0] ph_len;

	// bus clock ticks
	hbs_bclk_div #(.HALF(HALF)) u_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.lk(lk.gen)
	);

	// pin synchronisers
	hbs_pin_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_wait_ready_in(i_wait_ready_in),
		.i_aux_wait_pin(i_aux_wait_pin),
		.i_ad_in(i_ad_in),
		.lk(lk.snc)
	);

	// command handshake and cycle kind
	assign take = i_cmd_valid && st.ready;
	assign is_rd = (st.op == HBS_OP_RD) || (st.op == HBS_OP_XRD);

	// length of the running phase in bus clocks
	always_comb begin
		ph_len = PH_BASE_CLKS;
		if (st.stretch) begin
			unique case (st.state)
				S_ALE: ph_len = ALE_WAIT_CLKS; // RL3 RL10
				S_CSPH: ph_len = RDCS_WAIT_CLKS; // RL11
				S_RDLO: ph_len = RD_WAIT_CLKS; // RL14
				S_WRLO: ph_len = WR_WAIT_CLKS; // RL6
				default: ph_len = PH_BASE_CLKS;
			endcase
		end
	end

	// sequencer next state
	always_comb begin
		next_st = st;
		next_st.rd_valid = 1'b0;
		// bus clock pin follows the ticks
		if (lk.tick_r) begin
			next_st.bclk = 1'b1; // RL16
		end else if (lk.tick_f) begin
			next_st.bclk = 1'b0; // RL16
		end
		unique case (st.state)
			S_IDLE: begin
				next_st.ready = 1'b1;
				if (take) begin
					next_st.ready = 1'b0;
					next_st.op = i_cmd_op;
					next_st.addr = i_cmd_addr;
					next_st.wdata = i_cmd_wdata;
					next_st.cnt = 3'h0;
					unique case (i_cmd_op)
						HBS_OP_XWR, HBS_OP_XRD: begin
							// high byte on its own lines first
							next_st.ext_addr = i_cmd_addr[15:8]; // RL1 RL18
							next_st.state = S_HI;
						end
						HBS_OP_WR, HBS_OP_RD: begin
							next_st.state = S_LO; // RL9 RL20
							next_st.ad_out = i_cmd_addr[7:0];
							next_st.ad_oe = 1'b1;
							// take lands mid-clock: skip that partial clock
							next_st.cnt = 3'h1; // RL2
						end
						HBS_OP_AUXHI, HBS_OP_AUXLO: begin
							next_st.state = S_AUX; // RL19
						end
					endcase
				end
			end
			S_HI: begin
				// low byte follows at the next bus clock
				if (lk.tick_r) begin
					next_st.ad_out = st.addr[7:0]; // RL1
					next_st.ad_oe = 1'b1;
					next_st.state = S_LO;
				end
			end
			S_LO: begin
				// one whole bus clock of address setup
				if (lk.tick_r) begin
					next_st.cnt = 3'h0;
					if (st.cnt == 3'h0) begin
						next_st.ale = 1'b1; // RL2
						next_st.stretch = lk.wait_low; // RL17
						next_st.state = S_ALE;
					end
				end
			end
			S_ALE: begin
				if (lk.tick_r) begin
					next_st.cnt = st.cnt + 3'h1;
					// read select always one clock after latch rises
					if (is_rd) begin
						next_st.cs_n = 1'b0; // RL12
					end
					if (st.cnt == ph_len - 3'h1) begin
						next_st.ale = 1'b0;
						next_st.cs_n = 1'b0; // RL4
						next_st.cnt = 3'h0;
						next_st.stretch = lk.wait_low; // RL17
						if (is_rd) begin
							next_st.state = S_CSPH;
						end else begin
							next_st.ad_out = st.wdata; // RL5
							next_st.state = S_DSET;
						end
					end
				end
			end
			S_DSET: begin
				// one bus clock of data setup before the strobe
				if (lk.tick_r) begin
					next_st.wr_n = 1'b0; // RL5
					next_st.stretch = lk.wait_low; // RL17
					next_st.cnt = 3'h0;
					next_st.state = S_WRLO;
				end
			end
			S_WRLO: begin
				if (lk.tick_r) begin
					next_st.cnt = st.cnt + 3'h1;
					if (st.cnt == ph_len - 3'h1) begin
						next_st.wr_n = 1'b1; // RL6
						next_st.state = S_WEND;
					end
				end
			end
			S_WEND: begin
				// select released at the falling edge, data held
				if (lk.tick_f) begin
					next_st.cs_n = 1'b1; // RL7 RL8
					next_st.state = S_IDLE;
				end
			end
			S_CSPH: begin
				if (lk.tick_r) begin
					next_st.cnt = st.cnt + 3'h1;
					if (st.cnt == ph_len - 3'h1) begin
						next_st.ad_oe = 1'b0; // RL13
						next_st.rd_n = 1'b0; // RL13
						next_st.stretch = lk.wait_low; // RL17
						next_st.cnt = 3'h0;
						next_st.state = S_RDLO;
					end
				end
			end
			S_RDLO: begin
				if (lk.tick_r) begin
					next_st.cnt = st.cnt + 3'h1;
					if (st.cnt == ph_len - 3'h1) begin
						next_st.rd_n = 1'b1; // RL14
						next_st.rd_data = lk.din;
						next_st.rd_valid = 1'b1;
						next_st.state = S_REND;
					end
				end
			end
			S_REND: begin
				// half a clock later: select off, bus driven again
				if (lk.tick_f) begin
					next_st.cs_n = 1'b1; // RL15
					next_st.ad_oe = 1'b1; // RL15
					next_st.state = S_IDLE;
				end
			end
			S_AUX: begin
				// stall until the aux pin reaches the wanted level
				if (lk.aux_hi == (st.op == HBS_OP_AUXHI)) begin
					next_st.state = S_IDLE; // RL19
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= SEQ_RST;
		end else begin
			st <= next_st;
		end
	end

	// outputs straight from the state register
	assign o_cmd_ready = st.ready;
	assign o_rd_valid = st.rd_valid;
	assign o_rd_data = st.rd_data;
	assign o_ad_out = st.ad_out;
	assign o_ad_oe = st.ad_oe;
	assign o_ext_addr = st.ext_addr;
	assign o_ale = st.ale;
	assign o_cs_n = st.cs_n;
	assign o_rd_n = st.rd_n;
	assign o_wr_n = st.wr_n;
	assign o_bus_clock_out = st.bclk;

	// checks on the bus cycle
	localparam int HC = HALF;
	localparam int WR_MAX = 12 * HALF + 2;
	localparam int RD_MAX = 10 * HALF + 2;
	localparam int BCLK_MAX = 2 * HALF;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	sequence s_wr_up;
		$rose(st.wr_n);
	endsequence

	sequence s_rd_up;
		$rose(st.rd_n);
	endsequence

	sequence s_cs_up;
		$rose(st.cs_n);
	endsequence

	a_ext_high_first: assert property ( // RL1
		st.state == S_HI |-> st.ext_addr == st.addr[15:8] &&
			(st.op == HBS_OP_XWR || st.op == HBS_OP_XRD))
		else $error("extended high byte not on its lines");

	a_ale_addr_setup: assert property ( // RL2
		$rose(st.ale) |-> $past(st.state) == S_LO && st.ad_oe &&
			$stable(st.ad_out) && $past(st.state, BCLK_MAX) == S_LO &&
			$past(st.ad_out, BCLK_MAX) == st.ad_out)
		else $error("latch strobe rose without address setup");

	a_ale_cs_together: assert property ( // RL4
		$fell(st.ale) |-> !st.cs_n)
		else $error("latch strobe fell without select");

	a_wr_data_held: assert property ( // RL8
		!st.wr_n |=> st.ad_oe && $stable(st.ad_out))
		else $error("write data changed before select release");

	a_wr_low_bound: assert property ( // RL6
		$fell(st.wr_n) |-> ##[1:WR_MAX] s_wr_up)
		else $error("write strobe low too long");

	a_wr_cs_half: assert property ( // RL7
		s_wr_up |-> !st.cs_n ##[HC:HC] s_cs_up)
		else $error("write select not released half clock later");

	a_rd_hiz_strobe: assert property ( // RL13
		$fell(st.rd_n) |-> $fell(st.ad_oe))
		else $error("read strobe fell while bus driven");

	a_rd_low_bound: assert property ( // RL14
		$fell(st.rd_n) |-> ##[1:RD_MAX] s_rd_up)
		else $error("read strobe low too long");

	a_rd_cs_half: assert property ( // RL15
		s_rd_up |-> ##[HC:HC] (s_cs_up and $rose(st.ad_oe)))
		else $error("read end not half a clock after strobe");

	a_rd_cs_early: assert property ( // RL12
		$rose(st.ale) && is_rd |-> ##[BCLK_MAX:BCLK_MAX] $fell(st.cs_n))
		else $error("read select late after latch strobe");

	a_aux_stall: assert property ( // RL19
		st.state == S_AUX && lk.aux_hi != (st.op == HBS_OP_AUXHI)
			|=> st.state == S_AUX && !st.ready)
		else $error("aux wait left early");
endmodule // hbs_sequencer

//--- hdl/hbs_pkg.sv
// Purpose: shared constants and types of the host bus cycle sequencer
// Assumes: system clock of 125 MHz, bus clock made by division
// Notes: all phase lengths are counted in whole bus clock periods
package hbs_pkg;
	// system clock and the bus clock half period, in picoseconds
	localparam int CLK_PS = 8000;
	localparam int BCLK_HALF_PS = 41600;
	// longest half period that fits the typical figure, at least one
	localparam int BCLK_HALF_CYC = (BCLK_HALF_PS / CLK_PS < 1) ? 1 :
		BCLK_HALF_PS / CLK_PS;
	// phase lengths in bus clocks, plain and with the wait input low
	localparam logic [2:0] PH_BASE_CLKS = 3'h1;
	localparam logic [2:0] ALE_WAIT_CLKS = 3'h2;
	localparam logic [2:0] RDCS_WAIT_CLKS = 3'h3;
	localparam logic [2:0] RD_WAIT_CLKS = 3'h5;
	localparam logic [2:0] WR_WAIT_CLKS = 3'h6;
	// reset value of the multiplexed address/data bus
	localparam logic [7:0] AD_IDLE = 8'h00;

	// commands accepted on the user port
	typedef enum logic [2:0] {
		HBS_OP_WR, HBS_OP_RD, HBS_OP_XWR, HBS_OP_XRD,
		HBS_OP_AUXHI, HBS_OP_AUXLO
	} hbs_op_t;

	// sequencer states
	typedef enum logic [3:0] {
		S_IDLE, S_HI, S_LO, S_ALE, S_DSET, S_WRLO, S_WEND,
		S_CSPH, S_RDLO, S_REND, S_AUX
	} hbs_state_t;

	// whole state of the sequencer
	typedef struct packed {
		hbs_state_t state;
		hbs_op_t op;
		logic [2:0] cnt;
		logic stretch;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic bclk;
		logic ale;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] ad_out;
		logic ad_oe;
		logic [7:0] ext_addr;
		logic ready;
		logic rd_valid;
		logic [7:0] rd_data;
	} hbs_seq_t;

	localparam hbs_seq_t SEQ_RST = '{
		state: S_IDLE, op: HBS_OP_WR, cnt: 3'h0, stretch: 1'b0,
		addr: 16'h0000, wdata: 8'h00, bclk: 1'b0, ale: 1'b0,
		cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, ad_out: AD_IDLE,
		ad_oe: 1'b1, ext_addr: 8'h00, ready: 1'b0,
		rd_valid: 1'b0, rd_data: 8'h00
	};
endpackage

//--- hdl/hbs_link_if.sv
// Purpose: carries bus clock ticks and synchronised pins to the sequencer
// Assumes: one clock domain
// Notes: ticks are one-cycle pulses
`timescale 1ns/1ps
interface hbs_link_if;
	logic tick_r;
	logic tick_f;
	logic wait_low;
	logic aux_hi;
	logic [7:0] din;
	modport gen (output tick_r, output tick_f);
	modport snc (output wait_low, output aux_hi, output din);
	modport seq (input tick_r, input tick_f, input wait_low,
		input aux_hi, input din);
endinterface

//--- hdl/hbs_bclk_div.sv
// Purpose: divides the system clock into bus clock rise and fall ticks
// Assumes: HALF system clocks per bus clock half period
// Notes: the sequencer itself drives the bus clock pin from these ticks
`timescale 1ns/1ps
module hbs_bclk_div import hbs_pkg::*; #(
	parameter int HALF = BCLK_HALF_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// ticks out
	hbs_link_if.gen lk
);
	typedef struct packed {
		logic [7:0] cnt;
		logic lvl;
	} hbs_div_t;
	hbs_div_t s;
	hbs_div_t next_s;
	logic wrap;

	// end of a half period
	assign wrap = (s.cnt == 8'(HALF - 1));
	assign lk.tick_r = wrap && !s.lvl;
	assign lk.tick_f = wrap && s.lvl;

	// count the half period and flip the level
	always_comb begin
		next_s = s;
		next_s.cnt = s.cnt + 8'h01;
		if (wrap) begin
			next_s.cnt = 8'h00;
			next_s.lvl = !s.lvl;
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule // hbs_bclk_div

//--- hdl/hbs_pin_sync.sv
// Purpose: two-stage synchronisers for the pins read by the sequencer
// Assumes: pins are asynchronous to i_clk
// Notes: only the second stage is seen outside
`timescale 1ns/1ps
module hbs_pin_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// raw pins
	input wire logic i_wait_ready_in,
	input wire logic i_aux_wait_pin,
	input wire logic [7:0] i_ad_in,
	// synchronised levels
	hbs_link_if.snc lk
);
	typedef struct packed {
		logic [9:0] ff1;
		logic [9:0] ff2;
	} hbs_sync_t;
	hbs_sync_t s;
	hbs_sync_t next_s;

	// second stage feeds the sequencer
	assign lk.wait_low = !s.ff2[9];
	assign lk.aux_hi = s.ff2[8];
	assign lk.din = s.ff2[7:0];

	// shift the pins through two stages
	always_comb begin
		next_s.ff1 = {i_wait_ready_in, i_aux_wait_pin, i_ad_in};
		next_s.ff2 = s.ff1;
	end

	// state register, wait input idles high
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s <= {10'h300, 10'h300};
		end else begin
			s <= next_s;
		end
	end
endmodule // hbs_pin_sync

//--- test/hbs_periph.sv
// Purpose: behavioural peripheral on the multiplexed host bus
// Assumes: address taken as ale rises, write data kept at select release
// Notes: a released bus shows the inverse of the last byte driven
`timescale 1ns/1ps
module hbs_periph (
	// bus pins from the sequencer
	input wire logic i_ale,
	input wire logic i_cs_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_ad,
	input wire logic [7:0] i_ext,
	// a slow device asks for more time
	input wire logic i_slow,
	// pins back to the sequencer
	output logic [7:0] o_drv,
	output logic o_wait_n
);
	logic [7:0] mem [0:65535];
	logic [15:0] addr = 16'h0000;
	logic [7:0] wlat = 8'h00;
	logic [7:0] last = 8'hA5;
	logic wcyc = 1'b0;
	logic drv_en;
	// both address bytes taken as the latch strobe rises; at its fall
	// the bus turns to write data in the same step, a race
	always @(posedge i_ale) addr = {i_ext, i_ad};
	// data taken at strobe rise, spoilt if not still held at release
	always @(negedge i_wr_n) wcyc = 1'b1;
	always @(posedge i_wr_n) wlat = i_ad;
	always @(posedge i_cs_n) begin
		if (wcyc) mem[addr] = (i_ad === wlat) ? wlat : ~wlat;
		wcyc = 1'b0;
	end
	// drives only while selected with read strobe low
	assign drv_en = !i_cs_n && !i_rd_n;
	always @(negedge drv_en) last = mem[addr];
	assign o_drv = drv_en ? mem[addr] : ~last;
	// wait pin held low by a slow device
	assign o_wait_n = !i_slow;
endmodule // hbs_periph

//--- test/tb.sv
// Purpose: self-checking bench of the host bus cycle sequencer
// Assumes: HALF of 2 gives a bus clock of 4 system clocks
// Notes: phase widths are measured in system clocks at the pins
`timescale 1ns/1ps
module tb import hbs_pkg::*;;
	localparam int HALF = 2;
	localparam int P = 2 * HALF;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_cmd_valid = 1'b0;
	hbs_op_t i_cmd_op = HBS_OP_WR;
	logic [15:0] i_cmd_addr = 16'h0000;
	logic [7:0] i_cmd_wdata = 8'h00;
	logic i_aux_wait_pin = 1'b0;
	logic slow = 1'b0;
	logic [7:0] o_rd_data, o_ad_out, o_ext_addr, p_drv, ad_wire, rdat;
	logic o_cmd_ready, o_rd_valid, o_ad_oe, o_ale, o_cs_n, o_rd_n, o_wr_n;
	logic o_bus_clock_out, wait_n;
	logic pa = 1'b0;
	logic pcs = 1'b1;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	integer seed = 32'hE45698CC;
	int ac = 0, wc = 0, rc = 0, bc = 0, ga = 0, sc = 0;
	int ale_w, wr_w, rd_w, bh_w, a2c, rel_w;
	int pc = 0;
	int cs_w = 0;

	// clock and the resolved two-way bus
	always #4 i_clk = ~i_clk;
	assign ad_wire = o_ad_oe ? o_ad_out : p_drv;

	hbs_sequencer #(.HALF(HALF)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_cmd_valid(i_cmd_valid), .i_cmd_op(i_cmd_op),
		.i_cmd_addr(i_cmd_addr), .i_cmd_wdata(i_cmd_wdata),
		.o_cmd_ready(o_cmd_ready), .o_rd_valid(o_rd_valid),
		.o_rd_data(o_rd_data), .i_wait_ready_in(wait_n),
		.i_aux_wait_pin(i_aux_wait_pin), .i_ad_in(ad_wire),
		.o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe), .o_ext_addr(o_ext_addr),
		.o_ale(o_ale), .o_cs_n(o_cs_n), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
		.o_bus_clock_out(o_bus_clock_out));

	hbs_periph peer (.i_ale(o_ale), .i_cs_n(o_cs_n), .i_rd_n(o_rd_n),
		.i_wr_n(o_wr_n), .i_ad(ad_wire), .i_ext(o_ext_addr), .i_slow(slow),
		.o_drv(p_drv), .o_wait_n(wait_n));

	// closing report
	task stop_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// compare a width in clocks
	task chk_w(string n, int e, int g);
		checked++;
		if (e != g) begin
			err_count++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, g);
		end
	endtask

	// compare a byte
	task chk_b(string n, logic [7:0] e, logic [7:0] g);
		checked++;
		if (e !== g) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// present a command and hold it until taken
	task issue(hbs_op_t op, logic [15:0] a, logic [7:0] d);
		@(posedge i_clk);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_cmd_addr <= a;
		i_cmd_wdata <= d;
		do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
		i_cmd_valid <= 1'b0;
	endtask

	// wait for the sequencer to be idle again
	task finish;
		repeat (2) @(posedge i_clk);
		while (o_cmd_ready !== 1'b1) @(posedge i_clk);
	endtask

	// stall on the aux pin, then release it
	task aux(hbs_op_t op, logic lvl);
		@(posedge i_clk);
		i_aux_wait_pin <= !lvl;
		repeat (4) @(posedge i_clk);
		issue(op, 16'h0000, 8'h00);
		repeat (40) @(posedge i_clk);
		chk_b("aux_stall", 8'h00, {7'h00, o_cmd_ready});
		i_aux_wait_pin <= lvl;
		finish();
	endtask

	// pin monitor: widths, gaps and read data
	always @(posedge i_clk) begin
		if (o_ale) ac++; else if (ac != 0) begin ale_w = ac; ac = 0; end
		if (!o_wr_n) wc++; else if (wc != 0) begin wr_w = wc; wc = 0; end
		if (!o_rd_n) rc++; else if (rc != 0) begin rd_w = rc; rc = 0; end
		if (o_bus_clock_out) bc++; else if (bc != 0) begin bh_w = bc; bc = 0; end
		if (!o_cs_n && pcs) a2c = ga;
		if (o_ale && !pa) ga = 0;
		ga++;
		if (o_cs_n && !pcs) rel_w = sc;
		// select low, latch strobe low, before the strobe falls
		if (o_ale) begin
			pc = 0;
		end else if (!o_wr_n || !o_rd_n) begin
			if (pc != 0) cs_w = pc;
			pc = 0;
		end else if (!o_cs_n) begin
			pc++;
		end
		sc = (!o_wr_n || !o_rd_n) ? 0 : sc + 1;
		if (o_rd_valid === 1'b1) rdat = o_rd_data;
		pa = o_ale;
		pcs = o_cs_n;
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			stop_test();
		end
	end

	// main sequence: write then read back, fast and slow peripheral
	initial begin
		logic [15:0] addr;
		logic [7:0] data;
		logic ext;
		logic [7:0] hi;
		hi = 8'h00;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		finish();
		for (int i = 0; i < 12; i++) begin
			addr = 16'($random(seed));
			data = 8'($random(seed));
			if (i < 2) begin
				addr = i[0] ? 16'h0000 : 16'hFFFF;
				data = i[0] ? 8'hFF : 8'h00;
			end
			ext = i[1];
			slow <= i[0];
			issue(ext ? HBS_OP_XWR : HBS_OP_WR, addr, data);
			finish();
			chk_w("wr_ale", i[0] ? 2 * P : P, ale_w);
			chk_w("wr_cs", i[0] ? 2 * P : P, a2c);
			chk_w("wr_low", i[0] ? 6 * P : P, wr_w);
			chk_w("wr_setup", P, cs_w);
			chk_w("wr_rel", HALF, rel_w);
			if (ext) hi = addr[15:8];
			chk_b("ext_addr", hi, o_ext_addr);
			issue(ext ? HBS_OP_XRD : HBS_OP_RD, addr, 8'h00);
			finish();
			chk_w("rd_ale", i[0] ? 2 * P : P, ale_w);
			chk_w("rd_cs", P, a2c);
			chk_w("rd_csph", i[0] ? 3 * P : P, cs_w);
			chk_w("rd_low", i[0] ? 5 * P : P, rd_w);
			chk_w("rd_rel", HALF, rel_w);
			chk_b("rd_data", data, rdat);
			chk_w("bclk_high", HALF, bh_w);
			$display("test %0d done", i);
		end
		aux(HBS_OP_AUXHI, 1'b1);
		aux(HBS_OP_AUXLO, 1'b0);
		$display("test aux done");
		stop_test();
	end
endmodule // tb
